// ### design/gpio_port_defs.svh
// Purpose: offsets, field positions, reset values and widths of the I/O port
// Assumes: register port with word-wide index addressing
// Notes:   included by the port package and the port modules
`ifndef GPIO_PORT_DEFS_SVH
`define GPIO_PORT_DEFS_SVH

`define PORT_ADDR_W        4
`define PORT_DATA_W        8
`define PORT_PIN_MAX       8
`define OFS_OUTPUT_DATA    4'h0
`define OFS_DIRECTION      4'h1
`define OFS_INPUT_PINS     4'h2
`define OFS_MCU_CONTROL    4'h3
`define PUD_BIT_POS        6
`define RST_OUTPUT_DATA    8'h00
`define RST_DIRECTION      8'h00
`define RST_MCU_CONTROL    8'h00
`define SYNC_DELAY_CYCLES  1

`endif

// ### design/gpio_port_pkg.sv
// Purpose: shared types of the I/O port
// Assumes: gpio_port_defs.svh holds the offsets, widths, field positions and reset values
// Notes:   register selection decoded once in the top module
`include "gpio_port_defs.svh"

package gpio_port_pkg;

  typedef enum logic [1:0] {
    SEL_OUTPUT_DATA = 2'b00,
    SEL_DIRECTION   = 2'b01,
    SEL_INPUT_PINS  = 2'b10,
    SEL_MCU_CONTROL = 2'b11
  } reg_sel_type;

  typedef enum logic [1:0] {
    PIN_HIGH_Z   = 2'b00,
    PIN_PULLUP   = 2'b01,
    PIN_DRIVE_LO = 2'b10,
    PIN_DRIVE_HI = 2'b11
  } pin_mode_type;

endpackage

// ### design/gpio_pin_slice.sv
// Purpose: one pin of the port: data bit, direction bit, input synchroniser, pad control
// Assumes: write enables come from the port's decode, one cycle wide
// Notes:   pad controls are flops cleared by the asynchronous reset
`include "gpio_port_defs.svh"

module gpio_pin_slice
  import gpio_port_pkg::*;
(
  input  wire logic core_clk_in,
  input  wire logic rst_n_in,
  input  wire logic ce_in,
  input  wire logic data_we_in,
  input  wire logic data_wv_in,
  input  wire logic dir_we_in,
  input  wire logic dir_wv_in,
  input  wire logic toggle_in,
  input  wire logic global_pullup_disable_in,
  input  wire logic pad_in,
  output logic      data_out,
  output logic      dir_out,
  output logic      pin_out,
  output logic      pad_out,
  output logic      pad_oe_out,
  output logic      pullup_out
);

  logic         data_q;
  logic         data_d;
  logic         dir_q;
  logic         dir_d;
  logic         sync_lat;
  logic         pin_q;
  pin_mode_type mode_d;

  always_comb begin
    data_d = data_q;
    if (data_we_in) begin
      data_d = data_wv_in;
    end else if (toggle_in) begin
      data_d = ~data_q;                                      // [RULE4]
    end
    dir_d  = dir_we_in ? dir_wv_in : dir_q;
    mode_d = pin_mode_type'({dir_d, data_d});
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      data_q <= 1'b0;
      dir_q  <= 1'b0;
    end else if (ce_in) begin
      data_q <= data_d;
      dir_q  <= dir_d;
    end
  end

  ///////////////////////////////////////////////////////////////////////////
  // pad drive: decoded from the next register values so the pad follows the
  // write in the same edge; reset clears all three, so the pad floats at once
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pad_oe_out <= 1'b0;                                    // [RULE9]
      pad_out    <= 1'b0;
      pullup_out <= 1'b0;
    end else if (ce_in) begin
      unique case (mode_d)                                   // [RULE10]
        PIN_HIGH_Z: begin
          pad_oe_out <= 1'b0;
          pad_out    <= 1'b0;
          pullup_out <= 1'b0;
        end
        PIN_PULLUP: begin
          pad_oe_out <= 1'b0;
          pad_out    <= 1'b0;
          pullup_out <= ~global_pullup_disable_in;           // [RULE5] [RULE7]
        end
        PIN_DRIVE_LO: begin
          pad_oe_out <= 1'b1;                                // [RULE6]
          pad_out    <= 1'b0;                                // [RULE8]
          pullup_out <= 1'b0;                                // [RULE7]
        end
        PIN_DRIVE_HI: begin
          pad_oe_out <= 1'b1;                                // [RULE6]
          pad_out    <= 1'b1;                                // [RULE8]
          pullup_out <= 1'b0;
        end
      endcase
    end
  end

  ///////////////////////////////////////////////////////////////////////////
  // input synchroniser: latch open while the clock is high, closed while low;
  // a pad change driven by a write at a rising edge flows through the open
  // latch and lands in the pin register one period later
  always_latch begin
    if (core_clk_in && ce_in) begin
      sync_lat = pad_in;                                     // [RULE14] [RULE16]
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_q <= 1'b0;
    end else if (ce_in) begin
      pin_q <= sync_lat;                                     // [RULE14] [RULE15] [RULE13]
    end
  end

  assign data_out = data_q;
  assign dir_out  = dir_q;
  assign pin_out  = pin_q;

endmodule // gpio_pin_slice

// ### design/general_digital_io_port.sv
// Purpose: general digital I/O port with data, direction and input registers
// Assumes: registers reached over a plain strobe port, read data one cycle later
// Notes:   bit set/clear strobes model the single-bit I/O instructions
//
// How it works
// [RULE1] bit set/clear leaves other pins untouched
// [RULE2] three addresses: data, direction, input pins; the port also decodes a fourth, the control register
// [RULE3] input pins read-only; data, direction read/write
// [RULE4] writing one to input pins toggles data
// [RULE5] global pull-up disable kills every pull-up
// [RULE6] direction one is output, zero input
// [RULE7] input with data one enables pull-up
// [RULE8] output pin drives the data bit level
// [RULE9] reset tri-states pins without any clock
// [RULE10] direction/data pair decodes to four pin modes
// [RULE11] software passes an intermediate state to drive-high
// [RULE12] software passes an intermediate state to output-low
// [RULE13] pad level readable whatever the direction
// [RULE14] latch open on high clock, then register
// [RULE15] pad change seen after half to 1.5 periods
// [RULE16] software-driven value seen after one period
// [RULE17] software waits one cycle before reading back
// [RULE18] other pins unaffected by alternate functions
// [RULE19] port built from identical per-pin slices
`include "gpio_port_defs.svh"

module general_digital_io_port
  import gpio_port_pkg::*;
#(
  parameter int PIN_COUNT = `PORT_PIN_MAX
) (
  input  wire logic                      core_clk_in,
  input  wire logic                      rst_n_in,
  input  wire logic                      ce_in,
  input  wire logic [`PORT_ADDR_W-1:0]   addr_in,
  input  wire logic [`PORT_DATA_W-1:0]   wdata_in,
  input  wire logic                      wr_in,
  input  wire logic                      rd_in,
  input  wire logic                      bit_set_in,
  input  wire logic                      bit_clr_in,
  input  wire logic [2:0]                bit_idx_in,
  output logic      [`PORT_DATA_W-1:0]   rdata_out,
  input  wire logic [PIN_COUNT-1:0]      pad_in,
  output logic      [PIN_COUNT-1:0]      pad_out,
  output logic      [PIN_COUNT-1:0]      pad_oe_out,
  output logic      [PIN_COUNT-1:0]      pullup_out
);

  if (PIN_COUNT < 1 || PIN_COUNT > `PORT_PIN_MAX) begin : g_bad_count
    $error("PIN_COUNT must lie between 1 and the port width");
  end

  ///////////////////////////////////////////////////////////////////////////
  // decode

  logic                    sel_valid;
  reg_sel_type             sel;
  logic [`PORT_DATA_W-1:0] bit_mask;
  logic [`PORT_DATA_W-1:0] data_word;
  logic [`PORT_DATA_W-1:0] dir_word;
  logic [`PORT_DATA_W-1:0] pin_word;
  logic [`PORT_DATA_W-1:0] mcu_ctrl_q;
  logic [`PORT_DATA_W-1:0] data_we;
  logic [`PORT_DATA_W-1:0] data_wv;
  logic [`PORT_DATA_W-1:0] dir_we;
  logic [`PORT_DATA_W-1:0] dir_wv;
  logic [`PORT_DATA_W-1:0] toggle;
  logic                    any_write;

  always_comb begin
    sel_valid = 1'b1;
    unique case (addr_in)                                    // [RULE2]
      `OFS_OUTPUT_DATA: sel = SEL_OUTPUT_DATA;
      `OFS_DIRECTION:   sel = SEL_DIRECTION;
      `OFS_INPUT_PINS:  sel = SEL_INPUT_PINS;
      `OFS_MCU_CONTROL: sel = SEL_MCU_CONTROL;
      default: begin
        sel       = SEL_OUTPUT_DATA;
        sel_valid = 1'b0;
      end
    endcase
  end

  assign bit_mask  = 8'h01 << bit_idx_in;
  assign any_write = wr_in | bit_set_in | bit_clr_in;

  ///////////////////////////////////////////////////////////////////////////
  // per-pin write enables: a bit operation enables only its own pin, so a
  // neighbour is never rewritten with a stale value
  always_comb begin
    data_we = 8'h00;
    data_wv = 8'h00;
    dir_we  = 8'h00;
    dir_wv  = 8'h00;
    toggle  = 8'h00;
    if (any_write && sel_valid) begin
      unique case (sel)
        SEL_OUTPUT_DATA: begin
          if (wr_in) begin
            data_we = 8'hFF;
            data_wv = wdata_in;
          end else begin
            data_we = bit_mask;                              // [RULE1]
            data_wv = bit_set_in ? 8'hFF : 8'h00;
          end
        end
        SEL_DIRECTION: begin
          if (wr_in) begin
            dir_we = 8'hFF;
            dir_wv = wdata_in;
          end else begin
            dir_we = bit_mask;                               // [RULE1]
            dir_wv = bit_set_in ? 8'hFF : 8'h00;
          end
        end
        SEL_INPUT_PINS: begin
          // no storage here: ones toggle output data, zeros do nothing
          if (wr_in) begin
            toggle = wdata_in;                               // [RULE3] [RULE4]
          end else if (bit_set_in) begin
            toggle = bit_mask;                               // [RULE4]
          end
        end
        SEL_MCU_CONTROL: begin
          toggle = 8'h00;
        end
      endcase
    end
  end

  ///////////////////////////////////////////////////////////////////////////
  // control register holding the global pull-up disable; other bits stored
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mcu_ctrl_q <= `RST_MCU_CONTROL;
    end else if (ce_in && sel_valid && sel == SEL_MCU_CONTROL) begin
      if (wr_in) begin
        mcu_ctrl_q <= wdata_in;
      end else if (bit_set_in) begin
        mcu_ctrl_q <= mcu_ctrl_q | bit_mask;                 // [RULE1]
      end else if (bit_clr_in) begin
        mcu_ctrl_q <= mcu_ctrl_q & ~bit_mask;                // [RULE1]
      end
    end
  end

  ///////////////////////////////////////////////////////////////////////////
  // pin slices; unused upper pins read as zero

  for (genvar i = 0; i < `PORT_PIN_MAX; i++) begin : g_pin
    if (i < PIN_COUNT) begin : g_used
      gpio_pin_slice u_slice (                               // [RULE19] [RULE18]
        .core_clk_in              (core_clk_in),
        .rst_n_in                 (rst_n_in),
        .ce_in                    (ce_in),
        .data_we_in               (data_we[i]),
        .data_wv_in               (data_wv[i]),
        .dir_we_in                (dir_we[i]),
        .dir_wv_in                (dir_wv[i]),
        .toggle_in                (toggle[i]),
        .global_pullup_disable_in (mcu_ctrl_q[`PUD_BIT_POS]), // [RULE5]
        .pad_in                   (pad_in[i]),
        .data_out                 (data_word[i]),
        .dir_out                  (dir_word[i]),
        .pin_out                  (pin_word[i]),
        .pad_out                  (pad_out[i]),
        .pad_oe_out               (pad_oe_out[i]),
        .pullup_out               (pullup_out[i])
      );
    end else begin : g_unused
      assign data_word[i] = 1'b0;
      assign dir_word[i]  = 1'b0;
      assign pin_word[i]  = 1'b0;
    end
  end

  ///////////////////////////////////////////////////////////////////////////
  // read data: registered, valid the cycle after the strobe and only then;
  // unmapped addresses answer zero
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= 8'h00;
    end else if (ce_in) begin
      if (rd_in && sel_valid) begin
        unique case (sel)
          SEL_OUTPUT_DATA: rdata_out <= data_word;           // [RULE3]
          SEL_DIRECTION:   rdata_out <= dir_word;            // [RULE3]
          SEL_INPUT_PINS:  rdata_out <= pin_word;            // [RULE13]
          SEL_MCU_CONTROL: rdata_out <= mcu_ctrl_q;
        endcase
      end else begin
        rdata_out <= 8'h00;
      end
    end
  end

endmodule // general_digital_io_port

// ### tb/gpio_port_asserts.sv
// Purpose: protocol and pad-control checks of the I/O port
// Assumes: sees only the top module's ports
// Notes:   bound to every instance of the port
`include "gpio_port_defs.svh"
module gpio_port_asserts #(
  parameter int PIN_COUNT = 8
) (
  input wire logic                    core_clk_in,
  input wire logic                    rst_n_in,
  input wire logic                    ce_in,
  input wire logic [`PORT_ADDR_W-1:0] addr_in,
  input wire logic [`PORT_DATA_W-1:0] wdata_in,
  input wire logic                    wr_in,
  input wire logic                    rd_in,
  input wire logic                    bit_set_in,
  input wire logic                    bit_clr_in,
  input wire logic [2:0]              bit_idx_in,
  input wire logic [`PORT_DATA_W-1:0] rdata_out,
  input wire logic [PIN_COUNT-1:0]    pad_out,
  input wire logic [PIN_COUNT-1:0]    pad_oe_out,
  input wire logic [PIN_COUNT-1:0]    pullup_out
);
  timeunit 1ns;
  timeprecision 1ps;
  wire                 wt = ce_in & wr_in;
  wire [PIN_COUNT-1:0] wd = wdata_in[PIN_COUNT-1:0];
  wire [PIN_COUNT-1:0] bm = PIN_COUNT'(1) << bit_idx_in;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  ////////////////////////////////////////
  reset_idle_a: assert property ($rose(rst_n_in) |-> !pad_oe_out && !pullup_out)
    else $error("pads active after reset");
  dir_write_a: assert property (wt && addr_in == `OFS_DIRECTION |=> pad_oe_out == $past(wd))
    else $error("direction write not on pads");
  data_drive_a: assert property (wt && addr_in == `OFS_OUTPUT_DATA |=>
    (pad_out & pad_oe_out) == ($past(wd) & pad_oe_out)) else $error("drive level wrong");
  toggle_a: assert property (wt && addr_in == `OFS_INPUT_PINS |=> $stable(pad_oe_out) &&
    ((pad_out ^ $past(pad_out)) & pad_oe_out) == ($past(wd) & pad_oe_out))
    else $error("toggle wrong");
  bit_set_a: assert property (ce_in && bit_set_in && addr_in == `OFS_DIRECTION |=>
    pad_oe_out == ($past(pad_oe_out) | $past(bm))) else $error("bit set disturbs pins");
  bit_clr_a: assert property (ce_in && bit_clr_in && addr_in == `OFS_DIRECTION |=>
    pad_oe_out == ($past(pad_oe_out) & ~$past(bm))) else $error("bit clear disturbs pins");
  pull_drive_a: assert property ((pad_oe_out & pullup_out) == '0)
    else $error("pull-up on a driven pin");
  pud_off_a: assert property (wt && addr_in == `OFS_MCU_CONTROL && wdata_in[`PUD_BIT_POS]
    |-> ##2 pullup_out == '0) else $error("pull-up despite disable");
  rdata_idle_a: assert property (ce_in && !rd_in |=> rdata_out == '0)
    else $error("read data outside its cycle");
endmodule // gpio_port_asserts

bind general_digital_io_port gpio_port_asserts #(.PIN_COUNT(PIN_COUNT)) u_gpio_port_asserts (
  .core_clk_in, .rst_n_in, .ce_in, .addr_in, .wdata_in, .wr_in, .rd_in, .bit_set_in,
  .bit_clr_in, .bit_idx_in, .rdata_out, .pad_out, .pad_oe_out, .pullup_out);

// ### tb/gpio_pad_model.sv
// Purpose: pads and outside circuitry of the port
// Assumes: the port's own drive wins over any outside source
// Notes:   an undriven pin without pull-up shows a toggling level
module gpio_pad_model (
  input  wire logic       core_clk_in,
  input  wire logic [7:0] drive_in,
  input  wire logic [7:0] drive_en_in,
  input  wire logic [7:0] pullup_in,
  input  wire logic [7:0] ext_en_in,
  input  wire logic [7:0] ext_val_in,
  output logic      [7:0] level_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic flip_q = 1'b0;
  // floating pins keep changing so no test leans on a stale level
  always_ff @(posedge core_clk_in) flip_q <= ~flip_q;
  assign level_out = (drive_en_in & drive_in) | (~drive_en_in & ext_en_in & ext_val_in)
                   | (~drive_en_in & ~ext_en_in & (pullup_in | {8{flip_q}}));
endmodule // gpio_pad_model

// ### tb/general_digital_io_port_test.sv
// Purpose: self-checking bench of the I/O port
// Assumes: pads looped back through the pad model
// Notes:   each bus task (wr, rd, bop) spends two cycles, which also spaces write and read-back
module general_digital_io_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic       core_clk_in = 0, rst_n_in = 0, ce_in = 1, wr_in = 0, rd_in = 0;
  logic       bit_set_in = 0, bit_clr_in = 0;
  logic [3:0] addr_in = 0;
  logic [2:0] bit_idx_in = 0;
  logic [7:0] wdata_in = 0, ext_en = 0, ext_val = 0;
  logic [7:0] rdata_out, pad_out, pad_oe_out, pullup_out, pad_lvl;
  int         n_fail = 0, n_tests = 0;
  initial forever #5 core_clk_in = ~core_clk_in;
  general_digital_io_port #(.PIN_COUNT(8)) u_general_digital_io_port (.core_clk_in, .rst_n_in,
    .ce_in, .addr_in, .wdata_in, .wr_in, .rd_in, .bit_set_in, .bit_clr_in, .bit_idx_in,
    .rdata_out, .pad_in(pad_lvl), .pad_out, .pad_oe_out, .pullup_out);
  gpio_pad_model u_gpio_pad_model (.core_clk_in, .drive_in(pad_out), .drive_en_in(pad_oe_out),
    .pullup_in(pullup_out), .ext_en_in(ext_en), .ext_val_in(ext_val), .level_out(pad_lvl));
  ////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge core_clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge core_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge core_clk_in);
    rd_in <= 1'b0;
    #1 chk(rdata_out, exp);
  endtask
  task automatic bop(input logic s, input logic [3:0] a, input logic [2:0] i);
    @(posedge core_clk_in);
    addr_in <= a;
    bit_idx_in <= i;
    bit_set_in <= s;
    bit_clr_in <= !s;
    @(posedge core_clk_in);
    bit_set_in <= 1'b0;
    bit_clr_in <= 1'b0;
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (3) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    rd(4'h1, 8'h00);
    wr(4'h1, 8'hF0);
    wr(4'h0, 8'hA5);
    ext_en <= 8'h0F;
    ext_val <= 8'h09;
    rd(4'h0, 8'hA5);
    rd(4'h2, 8'hA9);
    chk(pullup_out, 8'h05);
    wr(4'h2, 8'h3C);
    rd(4'h0, 8'h99);
    rd(4'h1, 8'hF0);
    bop(1'b1, 4'h1, 3'd0);
    bop(1'b0, 4'h1, 3'd7);
    bop(1'b1, 4'h2, 3'd1);
    rd(4'h1, 8'h71);
    rd(4'h0, 8'h9B);
    chk(pullup_out, 8'h8A);
    chk(pad_out & pad_oe_out, 8'h11);
    rd(4'h2, 8'h99);
    wr(4'h3, 8'h40);
    repeat (2) @(posedge core_clk_in);
    #1 chk(pullup_out, 8'h00);
    rd(4'h3, 8'h40);
    wr(4'h3, 8'h00);
    repeat (2) @(posedge core_clk_in);
    #1 chk(pullup_out, 8'h8A);
    // pin 0 went pull-up, then drive high, now drive low
    bop(1'b0, 4'h0, 3'd0);
    #1 chk(pad_out & pad_oe_out, 8'h10);
    bop(1'b0, 4'h2, 3'd4);
    rd(4'h0, 8'h9A);
    wr(4'h5, 8'hFF);
    rd(4'h5, 8'h00);
    @(posedge core_clk_in);
    ce_in <= 1'b0;
    wr(4'h1, 8'h00);
    ce_in <= 1'b1;
    rd(4'h1, 8'h71);
    #3 rst_n_in = 1'b0;
    #1 chk(pad_oe_out | pullup_out, 8'h00);
    @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    rd(4'h1, 8'h00);
    give_verdict();
  end
  initial begin
    #20000;
    n_fail++;
    give_verdict();
  end
endmodule // general_digital_io_port_test
